// ### hw/adc_pkg.sv
package adc_pkg;
   localparam int RESULT_BITS       = 16;
   localparam int ADC_BITS          = 14;
   localparam int ACQ_EDGE          = 16;
   localparam int NAP_PULSES        = 2;
   localparam int SLEEP_PULSES      = 4;
   localparam int CNT_W             = 5;
   localparam int STROBE_CNT_W      = 3;
   localparam int SYS_CLK_MHZ       = 100;
   localparam int SETUP_NS          = 3;
   // late-strobe window in sys_clk cycles, rounded up, at least one
   localparam int SETUP_CYC_RAW     = (SETUP_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC         = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
   localparam int REF_SETTLE_MS     = 2;
   localparam int REF_SETTLE_CYC    = REF_SETTLE_MS * SYS_CLK_MHZ * 1000;

   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_NAP    = 2'b01,
      PWR_SLEEP  = 2'b10
   } pwr_e;
endpackage

// ### hw/word_buf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface word_buf_if #(parameter int W = 16);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport buf_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ### hw/word_buf.sv
`timescale 1ns/10ps
`default_nettype none
// two-entry skid buffer: a stalled drain loses no word
module word_buf #(
   parameter int W = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   word_buf_if.buf_side     bif
);
   logic [W-1:0] mem_r [2];
   logic         wr_ptr_r;
   logic         rd_ptr_r;
   logic [1:0]   count_r;
   wire          push = bif.in_valid && bif.in_ready;
   wire          pop  = bif.out_valid && bif.out_ready;

   assign bif.in_ready  = (count_r != 2'd2);
   assign bif.out_valid = (count_r != 2'd0);
   assign bif.out_data  = mem_r[rd_ptr_r];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= bif.in_data;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'd0;
      end else begin
         if (push) wr_ptr_r <= ~wr_ptr_r;
         if (pop)  rd_ptr_r <= ~rd_ptr_r;
         count_r <= count_r + 2'(push) - 2'(pop);
      end
   end

   a_buf_no_overflow: assert property (@(posedge sys_clk) disable iff (sys_rst)
      count_r == 2'd2 |-> !bif.in_ready) else $error("buffer full but ready");
   a_buf_stall_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      count_r == 2'd2 && !pop |=> bif.out_valid && bif.out_data == $past(bif.out_data))
      else $error("stalled word lost");
endmodule
`default_nettype wire

// ### hw/adc_sample_strobe_ctrl.sv
// Function
// - strobe rising under 3ns before a serial edge delays data by one clock.
// - acquisition opens at 16th rising serial edge, closes at next strobe rise.
// - serial clock may stretch arbitrarily while result bits are read.
// - serial result output is three-state and can be released.
// - each word is the input sampled at the previous conversion start.
// - result words are two's complement.
// - each serial rising edge advances conversion and the output bit.
// - any serial clock pulse in deep power-down wakes the device.
// - strobe rising edge holds input and starts a new conversion; the code does so only while power_state is active.
// - two strobe pulses with serial clock still enter light power-down.
// - four or more strobe pulses with serial clock still enter deep power-down.
// - result is shifted out over the 16 serial cycles after a strobe rise.
`timescale 1ns/10ps
`default_nettype none
module adc_sample_strobe_ctrl
   import adc_pkg::*;
#(
   parameter int ADC_W     = ADC_BITS,
   parameter int SETTLE_CYC = REF_SETTLE_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              sample_strobe,
   input  wire logic              serial_clk,
   input  wire logic [ADC_W-1:0]  sample_code,
   output logic                   serial_result_out,
   output logic                   serial_result_oe_n,
   output logic                   acq_window,
   output logic                   hold_sample,
   output logic [1:0]             power_state,
   output logic                   ref_settled,
   output logic                   word_valid,
   input  wire logic              word_ready,
   output logic [RESULT_BITS-1:0] word_data
);
   // refused at elaboration: the code must fit the 16-bit frame
   if (ADC_W < 1 || ADC_W > RESULT_BITS) begin : g_bad_adc_w
      $error("ADC_W out of range");
   end
   if (SETTLE_CYC < 0) begin : g_bad_settle
      $error("SETTLE_CYC must not be negative");
   end

   // pin synchronisers, first stage read only by second
   logic [1:0] strb_sync_r;
   logic [1:0] sck_sync_r;
   logic       strb_d_r;
   logic       sck_d_r;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strb_sync_r <= 2'b00;
         sck_sync_r  <= 2'b00;
         strb_d_r    <= 1'b0;
         sck_d_r     <= 1'b0;
      end else begin
         strb_sync_r <= {strb_sync_r[0], sample_strobe};
         sck_sync_r  <= {sck_sync_r[0], serial_clk};
         strb_d_r    <= strb_sync_r[1];
         sck_d_r     <= sck_sync_r[1];
      end
   end
   wire strb_rise = strb_sync_r[1] && !strb_d_r;
   wire sck_rise  = sck_sync_r[1] && !sck_d_r;
   wire sck_edge  = sck_sync_r[1] != sck_d_r;

   pwr_e                 pwr_r;
   pwr_e                 pwr_nxt;
   logic [STROBE_CNT_W-1:0] still_cnt_r;
   logic [CNT_W-1:0]     bit_cnt_r;
   logic                 shifting_r;
   logic                 acq_r;
   logic                 late_r;
   logic [$clog2(SETUP_CYC+1)-1:0] since_strb_r;
   logic [RESULT_BITS-1:0] cur_word_r;
   logic [RESULT_BITS-1:0] held_word_r;
   logic [RESULT_BITS-1:0] shift_r;
   logic                 sdo_r;
   logic                 oe_n_r;
   logic [31:0]          settle_cnt_r;

   // left-justify the two's complement code into the 16-bit frame
   function automatic logic [RESULT_BITS-1:0] frame_code(input logic [ADC_W-1:0] c);
      frame_code = RESULT_BITS'(c) << (RESULT_BITS - ADC_W);
   endfunction

   // power-down counting: strobes while the serial clock stands still
   wire [STROBE_CNT_W-1:0] still_inc =
      (still_cnt_r == STROBE_CNT_W'(SLEEP_PULSES)) ? still_cnt_r : still_cnt_r + 1'b1;
   always_comb begin
      pwr_nxt = pwr_r;
      if (sck_edge) begin
         if (pwr_r != PWR_ACTIVE) pwr_nxt = PWR_ACTIVE;
      end else if (strb_rise) begin
         if (still_inc >= STROBE_CNT_W'(SLEEP_PULSES))    pwr_nxt = PWR_SLEEP;
         else if (still_inc >= STROBE_CNT_W'(NAP_PULSES)) pwr_nxt = PWR_NAP;
      end
   end

   // a strobe next to a serial edge still converts; only the still count ignores it
   wire start_sample_strobe = strb_rise && pwr_r == PWR_ACTIVE;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_r       <= PWR_ACTIVE;
         still_cnt_r <= '0;
      end else begin
         pwr_r <= pwr_nxt;
         if (sck_edge)       still_cnt_r <= '0;
         else if (strb_rise) still_cnt_r <= still_inc;
      end
   end

   // reference settle timer after a sleep wake; reports only
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_cnt_r <= '0;
      end else if (pwr_r == PWR_SLEEP) begin
         settle_cnt_r <= 32'(SETTLE_CYC);
      end else if (settle_cnt_r != 32'h0) begin
         settle_cnt_r <= settle_cnt_r - 32'h1;
      end
   end
   assign ref_settled = (settle_cnt_r == 32'h0);

   // conversion sequencing on serial clock rising edges
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         since_strb_r <= '0;
         late_r       <= 1'b0;
         bit_cnt_r    <= '0;
         shifting_r   <= 1'b0;
         acq_r        <= 1'b1;
         cur_word_r   <= '0;
         held_word_r  <= '0;
         shift_r      <= '0;
         sdo_r        <= 1'b0;
         oe_n_r       <= 1'b1;
      end else begin
         if (since_strb_r != '0) since_strb_r <= since_strb_r - 1'b1;
         if (start_sample_strobe) begin
            // word out is the previous sample; new sample is held now
            held_word_r  <= cur_word_r;
            cur_word_r   <= frame_code(sample_code);
            acq_r        <= 1'b0;
            bit_cnt_r    <= '0;
            shifting_r   <= 1'b1;
            late_r       <= 1'b0;
            shift_r      <= cur_word_r;
            since_strb_r <= ($bits(since_strb_r))'(SETUP_CYC);
         end else if (sck_rise && pwr_r == PWR_ACTIVE) begin
            if (shifting_r && since_strb_r != '0 && bit_cnt_r == '0 && !late_r) begin
               late_r <= 1'b1;
            end else if (shifting_r) begin
               // no timeout: stretched serial clock keeps the frame
               sdo_r     <= shift_r[RESULT_BITS-1];
               shift_r   <= {shift_r[RESULT_BITS-2:0], 1'b0};
               oe_n_r    <= 1'b0;
               bit_cnt_r <= bit_cnt_r + 1'b1;
               if (bit_cnt_r == CNT_W'(RESULT_BITS-1)) begin
                  shifting_r <= 1'b0;
                  acq_r      <= 1'b1;
               end
            end else begin
               oe_n_r <= 1'b1;
            end
         end
      end
   end

   // completed words leave through the buffer
   word_buf_if #(.W(RESULT_BITS)) wb ();
   logic push_pend_r;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         push_pend_r <= 1'b0;
      end else if (start_sample_strobe) begin
         push_pend_r <= 1'b1;
      end else if (wb.in_ready) begin
         push_pend_r <= 1'b0;
      end
   end
   assign wb.in_valid  = push_pend_r;
   assign wb.in_data   = held_word_r;
   assign wb.out_ready = word_ready;
   word_buf #(.W(RESULT_BITS)) u_buf (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .bif     (wb)
   );

   assign word_valid         = wb.out_valid;
   assign word_data          = wb.out_data;
   assign serial_result_out  = sdo_r;
   assign serial_result_oe_n = oe_n_r;
   assign acq_window         = acq_r;
   assign hold_sample        = !acq_r;
   assign power_state        = pwr_r;

   sequence s_strobe_still;
      strb_rise && !sck_edge && still_inc >= STROBE_CNT_W'(SLEEP_PULSES);
   endsequence
   sequence s_late_rise;
      start_sample_strobe ##1 (sck_rise && pwr_r == PWR_ACTIVE && !start_sample_strobe && since_strb_r != '0);
   endsequence
   a_sleep_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_strobe_still |=> pwr_r == PWR_SLEEP) else $error("sleep not entered");
   a_nap_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
      strb_rise && !sck_edge && still_inc == STROBE_CNT_W'(NAP_PULSES) && pwr_r == PWR_ACTIVE
      |=> pwr_r == PWR_NAP) else $error("nap not entered");
   a_wake_on_clk: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sck_edge && pwr_r == PWR_SLEEP |=> pwr_r == PWR_ACTIVE) else $error("no wake");
   a_hiz_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !shifting_r && sck_rise && !start_sample_strobe |=> oe_n_r) else $error("output not released");
   a_acq_close: assert property (@(posedge sys_clk) disable iff (sys_rst)
      start_sample_strobe |=> !acq_window) else $error("acquisition not closed");
   a_pipe_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
      start_sample_strobe |=> held_word_r == $past(cur_word_r)) else $error("pipeline word wrong");
   a_late_skip: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_late_rise |=> late_r && bit_cnt_r == '0 && oe_n_r == $past(oe_n_r))
      else $error("late strobe not delayed");
   a_bit_advance: assert property (@(posedge sys_clk) disable iff (sys_rst)
      shifting_r && sck_rise && pwr_r == PWR_ACTIVE && !start_sample_strobe && since_strb_r == '0
      |=> bit_cnt_r == $past(bit_cnt_r) + 1'b1) else $error("bit did not advance");
   a_frame_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
      shifting_r && sck_rise && pwr_r == PWR_ACTIVE && !start_sample_strobe && bit_cnt_r == CNT_W'(RESULT_BITS-1)
      |=> !shifting_r && acq_window) else $error("frame did not end");
endmodule
`default_nettype wire

// ### bench/adc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side: the serial clock stands still between frames
module adc_host_model (
   output logic      serial_clk,
   output logic      sample_strobe,
   input  wire logic sdo_line
);
   initial begin
      serial_clk    = 1'b0;
      sample_strobe = 1'b0;
   end
   // late puts the first rise one sys_clk after the strobe
   task automatic frame(input bit late, input realtime h, output logic [15:0] w);
      int n;
      n = late ? 1 : 0;
      w = 16'h0000;
      #3.7;
      sample_strobe = 1'b1;
      #(late ? 10.0 : h);
      for (int i = 0; i < 18 + n; i++) begin
         if (i > n && i <= 16 + n) w = {w[14:0], sdo_line};
         serial_clk    = 1'b1;
         sample_strobe = 1'b0;
         #(h);
         serial_clk = 1'b0;
         #(h);
      end
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         #40.2;
         sample_strobe = 1'b1;
         #40;
         sample_strobe = 1'b0;
      end
   endtask
   task automatic tick();
      #3.7;
      serial_clk = 1'b1;
      #62.5;
      serial_clk = 1'b0;
      #62.5;
   endtask
endmodule
`default_nettype wire

// ### bench/serial_adc_conversion_interface_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_adc_conversion_interface_test import adc_pkg::*;;
   logic                   sys_clk;
   logic                   sys_rst;
   logic [ADC_BITS-1:0]    sample_code;
   logic [ADC_BITS-1:0]    prev;
   logic                   word_ready;
   wire                    serial_clk;
   wire                    sample_strobe;
   wire                    sdo_line;
   logic                   sdo_r;
   logic                   oe_n;
   logic                   acq_window;
   logic                   hold_sample;
   logic                   word_valid;
   logic                   ref_settled;
   logic [1:0]             power_state;
   logic [RESULT_BITS-1:0] word_data;
   logic [RESULT_BITS-1:0] w;
   logic [RESULT_BITS-1:0] exp_q[$];
   logic [31:0]            seed;
   logic [31:0]            rdy_s;
   int                     n_fail;
   int                     comparisons;
   int                     cyc;
   bit                     chk_en;
   bit                     stall;

   assign sdo_line = oe_n ? 1'bz : sdo_r;

   adc_sample_strobe_ctrl #(.SETTLE_CYC(20)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sample_strobe(sample_strobe),
      .serial_clk(serial_clk), .sample_code(sample_code), .serial_result_out(sdo_r), .serial_result_oe_n(oe_n),
      .acq_window(acq_window), .hold_sample(hold_sample), .power_state(power_state), .ref_settled(ref_settled),
      .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
   adc_host_model u_host (.serial_clk(serial_clk), .sample_strobe(sample_strobe), .sdo_line(sdo_line));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [RESULT_BITS-1:0] exp_word(input logic [ADC_BITS-1:0] c);
      return {c, {(RESULT_BITS-ADC_BITS){1'b0}}};
   endfunction
   task automatic chk_bit(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic run_frame(input bit late, input realtime h, input logic [ADC_BITS-1:0] c);
      logic [RESULT_BITS-1:0] e;
      @(posedge sys_clk);
      #1;
      e = exp_word(prev);
      sample_code = c;
      if (chk_en) exp_q.push_back(e);
      fork
         u_host.frame(late, h, w);
         begin
            repeat (30) @(posedge sys_clk);
            chk_bit("acq window", 1'b0, acq_window);
            chk_bit("hold", 1'b1, hold_sample);
         end
      join
      prev = c;
      if (chk_en) chk_word("serial word", e, w);
      chk_bit("line released", 1'b1, oe_n);
      chk_bit("acq window", 1'b1, acq_window);
   endtask

   // drain side: random stalls, and a forced one that fills both entries
   // a hang still reaches the closing report
   initial begin
      wait (cyc == 20000);
      n_fail++;
      complete_run();
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (word_valid === 1'b1 && word_ready === 1'b1 && chk_en)
         chk_word("buffer word", exp_q.size() > 0 ? exp_q.pop_front() : 'x, word_data);
      #1;
      word_ready = !stall && rdy_s[3];
      rdy_s = xs(rdy_s);
   end

   initial begin
      sys_rst = 1'b1;
      sample_code = '0;
      word_ready = 1'b0;
      seed = 32'h000101d7;
      rdy_s = xs(32'h000101d7);
      prev = '0;
      repeat (2) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      // the first word carries the pipeline's reset content
      run_frame(1'b0, 62.5, 14'h0155);
      repeat (20) @(posedge sys_clk);
      chk_en = 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         stall = (i == 5 || i == 6);
         run_frame(i == 3, (i == 4) ? 400.0 : 62.5, i == 0 ? 14'h1fff : i == 1 ? 14'h2000 :
                   i == 2 ? 14'h3fff : seed[ADC_BITS-1:0]);
         if (i == 6) begin
            chk_bit("buffer full", 1'b1, word_valid);
            chk_word("buffer head", exp_q[0], word_data);
         end
      end
      stall = 1'b0;
      for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge sys_clk);
      chk_word("words left", 16'h0000, 16'(exp_q.size()));
      $display("test frames done");
      chk_en = 1'b0;
      u_host.pulses(2);
      repeat (5) @(posedge sys_clk);
      chk_word("power state", {14'h0000, PWR_NAP}, {14'h0000, power_state});
      u_host.tick();
      u_host.pulses(4);
      repeat (5) @(posedge sys_clk);
      chk_word("power state", {14'h0000, PWR_SLEEP}, {14'h0000, power_state});
      u_host.tick();
      chk_word("power state", {14'h0000, PWR_ACTIVE}, {14'h0000, power_state});
      chk_bit("ref settled", 1'b0, ref_settled);
      for (int k = 0; k < 100 && ref_settled !== 1'b1; k++) @(posedge sys_clk);
      chk_bit("ref settled", 1'b1, ref_settled);
      $display("test power done");
      complete_run();
   end
endmodule
`default_nettype wire
